// ### pmsp_pkg.sv
// Register map, field positions, timing and types of the parallel port
//----------------------------------------------------------------------
// Function
// - Port enable gates every off-chip access
// - Idle-stop bit freezes port in idle mode
// - Mux field picks address placement on pins
// - Strobe and byte-enable pins individually enabled
// - Chip-select function code 10 enables select
// - Polarity bits set latch, select, byte-enable levels
// - Polarity ignored on pins used as address
// - Write polarity covers enable strobe in mode1
// - Read polarity covers read/write strobe in mode1
// - Busy flag shows master transfer in progress
// - Interrupt mode selects cycle or buffer-3 interrupt
// - Interrupt mode 10 stalls processor instead
// - Step mode adjusts address after each cycle
// - Wide mode makes two byte transfers
// - Port mode field selects master or slave
// - Setup wait 1-4 cycles, also address phase
// - Strobe wait adds 0-15 cycles
// - Hold wait keeps data 1-4 cycles
// - Setup and hold ignored when strobe wait zero
// - Address-register select bit drives chip select
// - Address register drives eleven address outputs
//----------------------------------------------------------------------
package pmsp_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_ADDRESS = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam logic [7:0] OFF_SLAVE_OUT = 8'h10;
  localparam logic [7:0] OFF_SLAVE_IN = 8'h14;
  // Control register fields
  localparam int C_EN = 15;
  localparam int C_IDLE = 13;
  localparam int C_MUX = 11;
  localparam int C_BEEN = 10;
  localparam int C_WREN = 9;
  localparam int C_RDEN = 8;
  localparam int C_CSF = 6;
  localparam int C_ALP = 5;
  localparam int C_CSP = 3;
  localparam int C_BEP = 2;
  localparam int C_WRITE_STROBE_POLARITY = 1;
  localparam int C_READ_STROBE_POLARITY = 0;
  localparam logic [15:0] CONTROL_MASK = 16'hBFEF;
  // Mode register fields
  localparam int M_BUSY = 15;
  localparam int M_IRQ = 13;
  localparam int M_STEP = 11;
  localparam int M_WIDE = 10;
  localparam int M_PORT = 8;
  localparam int M_WB = 6;
  localparam int M_WM = 2;
  localparam int M_WE = 0;
  localparam logic [15:0] MODE_MASK = 16'h7FFF;
  // Address register fields
  localparam int A_CS = 14;
  localparam logic [15:0] ADDRESS_MASK = 16'h47FF;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Field codes
  localparam logic [1:0] MUX_SEP = 2'h0;
  localparam logic [1:0] MUX_PART = 2'h1;
  localparam logic [1:0] MUX_FULL = 2'h2;
  localparam logic [1:0] CSF_CHIP = 2'h2;
  localparam logic [1:0] IRQ_CYCLE = 2'h1;
  localparam logic [1:0] IRQ_STALL = 2'h2;
  localparam logic [1:0] IRQ_BUF3 = 2'h3;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;
  localparam logic [1:0] STEP_BUF = 2'h3;
  localparam logic [1:0] PORT_LEGACY = 2'h0;
  localparam logic [1:0] PORT_ADDRS = 2'h1;
  localparam logic [1:0] PORT_MASTER1 = 2'h3;
  localparam logic [1:0] LAST_BUF = 2'h3;
  // Instruction cycle timing
  localparam int CLOCK_NS = 5;
  localparam int TCY_NS = 10;
  localparam int TCY_CYCLES = (TCY_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [3:0] TCY_LAST = 4'(TCY_CYCLES - 1);
  // Master sequence, Gray from idle through hold, not on the step back to idle
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_SETUP = 3'h3,
    ST_STROBE = 3'h2,
    ST_HOLD = 3'h6
  } pmsp_state_type;
  // Control pins of the port
  typedef struct packed {
    logic chip_select_pin;
    logic read_strobe_pin;
    logic write_strobe_pin;
    logic byte_enable_pin;
  } pmsp_ctrl_type;
endpackage : pmsp_pkg

// ### pmsp_top.sv
// Parallel master/slave port with APB register access
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pmsp_top
  import pmsp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic IDLE_MODE,
  input wire logic [7:0] DATA_PINS_IN,
  output logic [7:0] DATA_PINS_OUT,
  output logic DATA_PINS_OE_N,
  input wire logic [1:0] ADDRESS_PINS_IN,
  output logic [10:0] ADDRESS_PINS_OUT,
  output logic ADDRESS_PINS_OE_N,
  input wire pmsp_ctrl_type CTRL_PINS_IN,
  output pmsp_ctrl_type CTRL_PINS_OUT,
  output pmsp_ctrl_type CTRL_PINS_OE_N,
  output logic IRQ,
  output logic STALL
);

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  // Pin level for an active flag under a polarity bit
  function automatic logic level(input logic act, input logic pol);
    return ~(act ^ pol);
  endfunction : level

  // Phase length in instruction cycles
  function automatic logic [4:0] len_of(input pmsp_state_type s, input logic [15:0] m);
    logic [4:0] r;
    r = 5'h01;
    unique case (s)
      ST_ADDR: r = (m[M_WM +: 4] == 4'h0) ? 5'h01 : 5'({3'h0, m[M_WB +: 2]} + 5'h01);
      ST_SETUP: r = 5'({3'h0, m[M_WB +: 2]} + 5'h01);
      ST_STROBE: r = 5'({1'h0, m[M_WM +: 4]} + 5'h01);
      ST_HOLD: r = 5'({3'h0, m[M_WE +: 2]} + 5'h01);
      default: r = 5'h01;
    endcase
    return r;
  endfunction : len_of

  //--------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------
  logic [15:0] control, next_control;
  logic [15:0] mode, next_mode;
  logic [15:0] address, next_address;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic [7:0] sl_out [4];
  logic [7:0] next_sl_out [4];
  logic [7:0] sl_in [4];
  logic [7:0] next_sl_in [4];
  logic [1:0] ptr, next_ptr;
  logic rd_prev, wr_prev;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  pmsp_state_type state, next_state, data_st;
  logic [4:0] cnt, next_cnt;
  logic second, next_second;
  logic aphase, next_aphase;
  logic is_read, next_is_read;
  logic [3:0] div, next_div;
  logic tick, halt, wm_zero, master, apb_acc, start, byte_end, done;
  logic cs_act, rd_act, wr_act, sl_irq;
  logic [1:0] sl_idx;
  logic [7:0] next_dout;
  logic next_doe_n, next_aoe_n, next_irq, next_stall;
  logic [10:0] next_aout;
  pmsp_ctrl_type next_cout, next_coe_n;

  assign master = mode[M_PORT + 1];
  assign wm_zero = (mode[M_WM +: 4] == 4'h0);
  assign data_st = wm_zero ? ST_STROBE : ST_SETUP;
  assign halt = ~control[C_EN] | (control[C_IDLE] & IDLE_MODE);
  assign apb_acc = PSEL & PENABLE & PREADY;
  assign start = apb_acc && PADDR == OFF_DATA && control[C_EN] && !halt
                 && master && state == ST_IDLE;

  //--------------------------------------------------------------------
  // Instruction-cycle divider
  //--------------------------------------------------------------------
  // Stopped while halted, so idle freezes every wait count
  always_comb begin
    next_div = div;
    tick = 1'b0;
    if (!halt) begin
      if (div == TCY_LAST) begin
        next_div = 4'h0;
        tick = 1'b1;
      end else begin
        next_div = div + 4'h1;
      end
    end
    if (start) next_div = 4'h0; // Restart so every phase is whole cycles
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      div <= 4'h0;
    end else begin
      div <= next_div;
    end
  end

  //--------------------------------------------------------------------
  // APB slave and configuration registers
  //--------------------------------------------------------------------
  // Answer in the first access cycle; read data is fixed at setup
  always_comb begin
    next_control = control;
    next_mode = mode;
    next_sl_out = sl_out;
    next_pready = PSEL & ~PENABLE & ~PREADY;
    next_prdata = 32'h0;
    next_pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      unique case (PADDR)
        OFF_CONTROL: next_prdata = {16'h0, control};
        OFF_MODE: next_prdata = {16'h0, state != ST_IDLE, mode[14:0]};
        OFF_ADDRESS: next_prdata = {16'h0, address};
        OFF_DATA: next_prdata = {16'h0, rdata};
        OFF_SLAVE_OUT: next_prdata = {sl_out[3], sl_out[2], sl_out[1], sl_out[0]};
        OFF_SLAVE_IN: next_prdata = {sl_in[3], sl_in[2], sl_in[1], sl_in[0]};
        default: next_pslverr = 1'b1;
      endcase
    end
    if (apb_acc && PWRITE) begin
      if (PADDR == OFF_CONTROL) next_control = PWDATA[15:0] & CONTROL_MASK;
      if (PADDR == OFF_MODE) next_mode = PWDATA[15:0] & MODE_MASK;
      if (PADDR == OFF_SLAVE_OUT) begin
        for (int i = 0; i < 4; i++) next_sl_out[i] = PWDATA[8 * i +: 8];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      control <= REG_RESET;
      mode <= REG_RESET;
      for (int i = 0; i < 4; i++) sl_out[i] <= 8'h00;
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      control <= next_control;
      mode <= next_mode;
      sl_out <= next_sl_out;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  //--------------------------------------------------------------------
  // Master transfer sequencer
  //--------------------------------------------------------------------
  // Data-register accesses while busy are dropped; software polls the busy flag
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_second = second;
    next_aphase = aphase;
    next_is_read = is_read;
    next_rdata = rdata;
    next_wdata = wdata;
    next_address = address;
    byte_end = 1'b0;
    done = 1'b0;
    if (apb_acc && PWRITE && PADDR == OFF_ADDRESS) begin
      next_address = PWDATA[15:0] & ADDRESS_MASK;
    end
    if (!control[C_EN]) begin
      next_state = ST_IDLE;
    end else if (state == ST_IDLE) begin
      if (start) begin
        next_is_read = ~PWRITE;
        if (PWRITE) next_wdata = PWDATA[15:0];
        next_second = 1'b0;
        next_aphase = 1'b0;
        next_state = (control[C_MUX +: 2] != MUX_SEP) ? ST_ADDR : data_st;
        next_cnt = len_of(next_state, mode);
      end
    end else if (tick) begin
      if (cnt != 5'h01) begin
        next_cnt = cnt - 5'h01;
      end else begin
        unique case (state)
          ST_ADDR: begin
            if (control[C_MUX +: 2] == MUX_FULL && !aphase) begin
              next_aphase = 1'b1;
              next_cnt = len_of(ST_ADDR, mode);
            end else begin
              next_state = data_st;
              next_cnt = len_of(data_st, mode);
            end
          end
          ST_SETUP: begin
            next_state = ST_STROBE;
            next_cnt = len_of(ST_STROBE, mode);
          end
          ST_STROBE: begin
            if (is_read && second) next_rdata[15:8] = DATA_PINS_IN;
            if (is_read && !second) next_rdata[7:0] = DATA_PINS_IN;
            // A wide zero-wait pair still needs a strobe gap between bytes
            if (wm_zero && (second || !mode[M_WIDE])) begin
              byte_end = 1'b1;
            end else begin
              next_state = ST_HOLD;
              next_cnt = wm_zero ? 5'h01 : len_of(ST_HOLD, mode);
            end
          end
          ST_HOLD: byte_end = 1'b1;
          default: next_state = ST_IDLE;
        endcase
      end
    end
    // Second byte reuses the address already latched outside
    if (byte_end) begin
      if (mode[M_WIDE] && !second) begin
        next_second = 1'b1;
        next_state = data_st;
        next_cnt = len_of(data_st, mode);
      end else begin
        next_state = ST_IDLE;
        done = 1'b1;
        unique case (mode[M_STEP +: 2])
          STEP_INC: next_address[10:0] = address[10:0] + 11'h001;
          STEP_DEC: next_address[10:0] = address[10:0] - 11'h001;
          default: next_address[10:0] = address[10:0];
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state <= ST_IDLE;
      cnt <= 5'h01;
      second <= 1'b0;
      aphase <= 1'b0;
      is_read <= 1'b0;
      rdata <= 16'h0000;
      wdata <= 16'h0000;
      address <= REG_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      second <= next_second;
      aphase <= next_aphase;
      is_read <= next_is_read;
      rdata <= next_rdata;
      wdata <= next_wdata;
      address <= next_address;
    end
  end

  //--------------------------------------------------------------------
  // Slave port toward an external host
  //--------------------------------------------------------------------
  // Host writes latch on strobe assertion, reads end on release
  assign cs_act = CTRL_PINS_IN.chip_select_pin == control[C_CSP];
  assign rd_act = cs_act && CTRL_PINS_IN.read_strobe_pin == control[C_READ_STROBE_POLARITY];
  assign wr_act = cs_act && CTRL_PINS_IN.write_strobe_pin == control[C_WRITE_STROBE_POLARITY];
  assign sl_idx = (mode[M_PORT +: 2] == PORT_ADDRS) ? ADDRESS_PINS_IN : ptr;

  always_comb begin
    next_sl_in = sl_in;
    next_ptr = ptr;
    sl_irq = 1'b0;
    if (control[C_EN] && !master && !halt) begin
      if (wr_act && !wr_prev) next_sl_in[sl_idx] = DATA_PINS_IN;
      if ((wr_act && !wr_prev) || (!rd_act && rd_prev)) begin
        if (mode[M_PORT +: 2] == PORT_LEGACY && mode[M_STEP +: 2] == STEP_BUF) begin
          next_ptr = ptr + 2'h1;
        end
        sl_irq = mode[M_IRQ +: 2] == IRQ_BUF3 && sl_idx == LAST_BUF;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      for (int i = 0; i < 4; i++) sl_in[i] <= 8'h00;
      ptr <= 2'h0;
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      sl_in <= next_sl_in;
      ptr <= next_ptr;
      rd_prev <= rd_act;
      wr_prev <= wr_act;
    end
  end

  //--------------------------------------------------------------------
  // Pin drive, interrupt and stall
  //--------------------------------------------------------------------
  // Pins follow state one cycle late; all waits shift together
  always_comb begin
    logic drv;
    logic strobe;
    logic xfer;
    drv = control[C_EN] & master;
    strobe = state == ST_STROBE;
    xfer = state != ST_IDLE;
    next_aoe_n = ~drv;
    next_aout = address[10:0];
    // Latch strobes replace address bits, so no polarity there otherwise
    if (control[C_MUX +: 2] != MUX_SEP) begin
      next_aout[1:0] = {level(state == ST_ADDR && aphase, control[C_ALP]),
                        level(state == ST_ADDR && !aphase, control[C_ALP])};
      if (control[C_MUX +: 2] == MUX_FULL) next_aout[10:2] = 9'h000;
    end
    next_dout = second ? wdata[15:8] : wdata[7:0];
    next_doe_n = ~(drv && xfer && (!is_read || state == ST_ADDR));
    if (state == ST_ADDR) next_dout = aphase ? {5'h00, address[10:8]} : address[7:0];
    if (control[C_EN] && !master && rd_act) begin
      next_dout = sl_out[sl_idx];
      next_doe_n = 1'b0;
    end
    next_cout.chip_select_pin = level(control[C_CSF +: 2] == CSF_CHIP && address[A_CS],
                                      control[C_CSP]);
    next_coe_n.chip_select_pin = ~(drv && control[C_CSF +: 2] == CSF_CHIP);
    if (mode[M_PORT +: 2] == PORT_MASTER1) begin
      next_cout.read_strobe_pin = level(is_read, control[C_READ_STROBE_POLARITY]);
      next_cout.write_strobe_pin = level(strobe, control[C_WRITE_STROBE_POLARITY]);
    end else begin
      next_cout.read_strobe_pin = level(strobe && is_read, control[C_READ_STROBE_POLARITY]);
      next_cout.write_strobe_pin = level(strobe && !is_read, control[C_WRITE_STROBE_POLARITY]);
    end
    next_cout.byte_enable_pin = level(xfer && mode[M_WIDE], control[C_BEP]);
    next_coe_n.read_strobe_pin = ~(drv && control[C_RDEN]);
    next_coe_n.write_strobe_pin = ~(drv && control[C_WREN]);
    next_coe_n.byte_enable_pin = ~(drv && control[C_BEEN] && mode[M_WIDE]);
    next_irq = (done && mode[M_IRQ +: 2] == IRQ_CYCLE) || sl_irq;
    next_stall = (next_state != ST_IDLE) && mode[M_IRQ +: 2] == IRQ_STALL;
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      DATA_PINS_OUT <= 8'h00;
      DATA_PINS_OE_N <= 1'b1;
      ADDRESS_PINS_OUT <= 11'h000;
      ADDRESS_PINS_OE_N <= 1'b1;
      CTRL_PINS_OUT <= 4'h0;
      CTRL_PINS_OE_N <= 4'hF;
      IRQ <= 1'b0;
      STALL <= 1'b0;
    end else begin
      DATA_PINS_OUT <= next_dout;
      DATA_PINS_OE_N <= next_doe_n;
      ADDRESS_PINS_OUT <= next_aout;
      ADDRESS_PINS_OE_N <= next_aoe_n;
      CTRL_PINS_OUT <= next_cout;
      CTRL_PINS_OE_N <= next_coe_n;
      IRQ <= next_irq;
      STALL <= next_stall;
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  a_off_no_access:
    assert property (@(posedge CLOCK) disable iff (RESET)
      !control[C_EN] |=> state == ST_IDLE && DATA_PINS_OE_N && ADDRESS_PINS_OE_N)
    else $error("port drives pins while disabled");

  a_idle_freeze:
    assert property (@(posedge CLOCK) disable iff (RESET)
      (control[C_EN] && control[C_IDLE] && IDLE_MODE) |=> $stable(state) && $stable(cnt))
    else $error("sequence moved while idle-stopped");

  a_start_busy:
    assert property (@(posedge CLOCK) disable iff (RESET)
      start |=> state != ST_IDLE ##1 state != ST_IDLE)
    else $error("busy did not follow a data access");

  a_stall_follow:
    assert property (@(posedge CLOCK) disable iff (RESET)
      (state != ST_IDLE && mode[M_IRQ +: 2] == IRQ_STALL && $stable(mode)) |-> STALL)
    else $error("stall missing during transfer");

  a_cycle_irq:
    assert property (@(posedge CLOCK) disable iff (RESET)
      (done && mode[M_IRQ +: 2] == IRQ_CYCLE) |=> IRQ ##1 !IRQ || sl_irq || done)
    else $error("end-of-cycle interrupt wrong");

  a_addr_step:
    assert property (@(posedge CLOCK) disable iff (RESET)
      (done && mode[M_STEP +: 2] == STEP_INC && !(apb_acc && PWRITE))
      |=> address[10:0] == $past(address[10:0]) + 11'h001)
    else $error("address did not step up");

  a_strobe_single:
    assert property (@(posedge CLOCK) disable iff (RESET)
      (state == ST_STROBE && wm_zero && tick && control[C_EN]) |=> state != ST_STROBE)
    else $error("strobe longer than one cycle");

  a_wide_two:
    assert property (@(posedge CLOCK) disable iff (RESET)
      done |-> (second == mode[M_WIDE]))
    else $error("wrong number of byte transfers");

  a_cs_drive:
    assert property (@(posedge CLOCK) disable iff (RESET)
      $stable(address) && $stable(control) && control[C_CSF +: 2] == CSF_CHIP
      |=> CTRL_PINS_OUT.chip_select_pin == ~($past(address[A_CS]) ^ $past(control[C_CSP])))
    else $error("chip select level wrong");

endmodule : pmsp_top

// ### pmsp_partner.sv
// Behavioural byte-wide partner on the far side of the parallel port: logs writes, answers reads from the address
`timescale 1ns/1ps
module pmsp_partner
  import pmsp_pkg::*;
(
  input wire logic clk,
  input wire logic wr_pol,
  input wire logic rd_pol,
  input wire pmsp_ctrl_type ctrl,
  input wire pmsp_ctrl_type ctrl_oe_n,
  input wire logic [10:0] addr,
  input wire logic [7:0] bus,
  output logic [7:0] data_out
);
  logic wr_on, rd_on, wr_d;
  logic [7:0] wr_data, idle_pat;
  logic [10:0] wr_addr;
  logic [15:0] wr_log;
  int wr_count, run, strobe_len;
  // Strobes count only while driven and at their programmed level
  assign wr_on = !ctrl_oe_n.write_strobe_pin && (ctrl.write_strobe_pin == wr_pol);
  assign rd_on = !ctrl_oe_n.read_strobe_pin && (ctrl.read_strobe_pin == rd_pol);
  // Idle bus toggles so a stale byte never passes for read data
  assign data_out = rd_on ? (addr[7:0] ^ 8'h5A) : idle_pat;
  initial begin
    {wr_count, run, strobe_len} = '0;
    {wr_log, wr_d, wr_addr, wr_data} = '0;
    idle_pat = 8'h3C;
  end
  // Latch on the last strobe cycle, log the byte when the strobe ends
  always @(posedge clk) begin
    idle_pat <= ~idle_pat;
    wr_d <= wr_on;
    if (wr_on) begin
      wr_data <= bus;
      wr_addr <= addr;
    end
    if (wr_d && !wr_on) begin
      wr_log <= {wr_log[7:0], wr_data};
      wr_count <= wr_count + 1;
    end
    if (wr_on || rd_on) run <= run + 1;
    else if (run != 0) begin
      strobe_len <= run;
      run <= 0;
    end
  end
endmodule : pmsp_partner

// ### test_parallel_master_slave_port.sv
// Self-checking bench: APB register access and master transfers
`timescale 1ns/1ps
module test_parallel_master_slave_port
  import pmsp_pkg::*;
;
  logic clock, reset, psel, penable, pwrite, idle_mode, err, irq, stall;
  logic pready, pslverr, dout_oe_n, aout_oe_n, wr_pol, rd_pol;
  logic [7:0] paddr, dout, bus, far_data;
  logic [31:0] pwdata, prdata, q;
  logic [10:0] aout;
  logic [15:0] masks [3];
  pmsp_ctrl_type ctrl_out, ctrl_oe_n, host;
  int err_count, num_checks, irq_count, snap;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  // Shared data wire: the port wins while it drives
  assign bus = dout_oe_n ? far_data : dout;
  always #2.5 clock = ~clock;
  always @(posedge clock) if (irq === 1'b1) irq_count <= irq_count + 1;
  pmsp_top DUT (.CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IDLE_MODE(idle_mode), .DATA_PINS_IN(bus), .DATA_PINS_OUT(dout),
    .DATA_PINS_OE_N(dout_oe_n), .ADDRESS_PINS_IN(2'h0), .ADDRESS_PINS_OUT(aout),
    .ADDRESS_PINS_OE_N(aout_oe_n), .CTRL_PINS_IN(host), .CTRL_PINS_OUT(ctrl_out),
    .CTRL_PINS_OE_N(ctrl_oe_n), .IRQ(irq), .STALL(stall));
  pmsp_partner far (.clk(clock), .wr_pol(wr_pol), .rd_pol(rd_pol), .ctrl(ctrl_out),
    .ctrl_oe_n(ctrl_oe_n), .addr(aout), .bus(bus), .data_out(far_data));
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; answer taken at the edge that samples ready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      finish_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll the busy flag, bounded so a hung port cannot stall the run
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_MODE, 32'h0);
      n++;
    end while (q[M_BUSY] !== 1'b0 && n < 200);
    if (q[M_BUSY] !== 1'b0) begin
      err_count++;
      finish_test();
    end
  endtask : wait_idle
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {clock, psel, penable, pwrite, idle_mode, wr_pol, rd_pol} = '0;
    {paddr, pwdata, err_count, num_checks} = '0;
    host = 4'hF;
    masks = '{CONTROL_MASK, MODE_MASK, ADDRESS_MASK};
    reset = 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    // Reset values, then writable bits of the control, mode and address registers
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(q, 32'(REG_RESET));
      apb(1'b1, 8'(4 * i), 32'hFFFF);
      apb(1'b0, 8'(4 * i), 32'h0);
      check(q, 32'(masks[i]));
    end
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    // Byte write, strobe wait 3, step up, cycle interrupt
    apb(1'b1, OFF_CONTROL, 32'h8388);
    apb(1'b1, OFF_MODE, 32'h2A0C);
    apb(1'b1, OFF_ADDRESS, 32'h4005);
    snap = irq_count;
    repeat (2) @(posedge clock);
    #1 check(32'(ctrl_out.chip_select_pin), 32'h1);
    apb(1'b1, OFF_DATA, 32'hA5);
    apb(1'b0, OFF_MODE, 32'h0);
    check(32'(q[M_BUSY]), 32'h1);
    wait_idle();
    check(32'(far.wr_log[7:0]), 32'hA5);
    check(32'(far.wr_addr), 32'h5);
    check(32'(far.strobe_len), 32'h8);
    apb(1'b0, OFF_ADDRESS, 32'h0);
    check(q, 32'h4006);
    check(32'(irq_count), 32'(snap + 1));
    // Wide write, no strobe wait, step down
    apb(1'b1, OFF_MODE, 32'h3600);
    apb(1'b1, OFF_DATA, 32'h1234);
    wait_idle();
    check(32'(far.wr_log), 32'h3412);
    check(32'(far.strobe_len), 32'h2);
    apb(1'b0, OFF_ADDRESS, 32'h0);
    check(q, 32'h4005);
    check(32'(irq_count), 32'(snap + 2));
    // Read with active-high strobes; result shows on the next read
    apb(1'b1, OFF_CONTROL, 32'h838B);
    @(posedge clock);
    wr_pol <= 1'b1;
    rd_pol <= 1'b1;
    apb(1'b1, OFF_MODE, 32'h2200);
    apb(1'b0, OFF_DATA, 32'h0);
    wait_idle();
    apb(1'b0, OFF_DATA, 32'h0);
    check(32'(q[7:0]), 32'h5F);
    wait_idle();
    // Stall mode holds the processor and raises no interrupt
    snap = irq_count;
    apb(1'b1, OFF_MODE, 32'h423C);
    apb(1'b1, OFF_DATA, 32'h66);
    repeat (2) @(posedge clock);
    #1 check(32'(stall), 32'h1);
    wait_idle();
    check(32'(stall), 32'h0);
    check(32'(irq_count), 32'(snap));
    // Disabled port makes no access
    snap = far.wr_count;
    apb(1'b1, OFF_CONTROL, 32'h038B);
    apb(1'b1, OFF_MODE, 32'h2200);
    apb(1'b1, OFF_DATA, 32'h77);
    repeat (20) @(posedge clock);
    wait_idle();
    check(32'(far.wr_count), 32'(snap));
    check(32'(aout_oe_n), 32'h1);
    // Idle mode freezes the port only with idle-stop set
    apb(1'b1, OFF_CONTROL, 32'hA38B);
    apb(1'b1, OFF_DATA, 32'h77);
    idle_mode <= 1'b1;
    repeat (20) @(posedge clock);
    check(32'(far.wr_count), 32'(snap));
    idle_mode <= 1'b0;
    wait_idle();
    snap = far.wr_count;
    apb(1'b1, OFF_CONTROL, 32'h838B);
    idle_mode <= 1'b1;
    apb(1'b1, OFF_DATA, 32'h78);
    wait_idle();
    check(32'(far.wr_count), 32'(snap + 1));
    // Master mode 1, partly muxed address, each wait one step up
    apb(1'b1, OFF_CONTROL, 32'h8BAB);
    apb(1'b1, OFF_MODE, 32'h2345);
    apb(1'b1, OFF_DATA, 32'hC3);
    wait_idle();
    check(32'(far.wr_log[7:0]), 32'hC3);
    check(32'(far.strobe_len), 32'h4);
    check(32'(aout[1:0]), 32'h0);
    // Legacy slave: a host read gets output buffer 0
    apb(1'b1, OFF_SLAVE_OUT, 32'h91);
    apb(1'b1, OFF_MODE, 32'h0);
    apb(1'b1, OFF_CONTROL, 32'h8380);
    host <= 4'h3;
    repeat (2) @(posedge clock);
    #1 check(32'({dout_oe_n, dout}), 32'h091);
    finish_test();
  end
endmodule : test_parallel_master_slave_port
